// >>> rtl/bfl_pkg.sv
/*
 * Shared constants and types for the bit, flag, load and store execution block.
 * Assumes a single 100 MHz clock and an APB master on the register side.
 */
package bfl_pkg;
	// Status flag bit positions in the flag register
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;
	localparam int FLAG_T = 6;
	localparam int FLAG_I = 7;
	// APB register byte addresses
	localparam logic [7:0] ADDR_INSTR = 8'h00;
	localparam logic [7:0] ADDR_OPERAND = 8'h04;
	localparam logic [7:0] ADDR_FLAGS = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;
	localparam logic [7:0] ADDR_REG_BASE = 8'h40;
	localparam logic [7:0] ADDR_MEM_BASE = 8'h80;
	// Register file and memory geometry and reset values
	localparam int NUM_REGS = 32;
	localparam int MEM_WORDS = 32;
	localparam int MEM_AW = 5;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	// Instruction timing in cycles
	localparam int CYC_SINGLE = 1;
	localparam int CYC_MEMORY = 2;
	// Pointer pair base register indices
	localparam logic [4:0] PTR_X_LO = 5'h1a;
	localparam logic [4:0] PTR_Y_LO = 5'h1c;
	localparam logic [4:0] PTR_Z_LO = 5'h1e;
	// Operation codes written to the instruction register
	typedef enum logic [4:0] {
		OP_NOP, OP_ROTATE_RIGHT_CARRY, OP_ARITH_SHIFT_RIGHT, OP_NIBBLE_SWAP,
		OP_FLAG_INDEX_RAISE, OP_FLAG_INDEX_DROP, OP_BIT_TO_TRANSFER_FLAG,
		OP_TRANSFER_FLAG_TO_BIT, OP_REG_COPY, OP_REG_PAIR_COPY, OP_IMMEDIATE_LOAD,
		OP_POINTER_READ, OP_OFFSET_POINTER_READ, OP_ABSOLUTE_READ, OP_POINTER_WRITE
	} bfl_op_e;
	// Pointer update modes
	typedef enum logic [1:0] {PTR_PLAIN, PTR_POST_INC, PTR_PRE_DEC} bfl_ptr_mode_e;
	// Decoded instruction word fields
	typedef struct packed {
		bfl_op_e op;
		bfl_ptr_mode_e mode;
		logic [1:0] ptr;
		logic [4:0] dst;
		logic [4:0] src;
		logic [2:0] bit_sel;
		logic [5:0] disp;
		logic [3:0] spare;
	} bfl_instr_s;
	// Memory request bundle
	typedef struct packed {
		logic we;
		logic [MEM_AW-1:0] addr;
		logic [7:0] wdata;
	} bfl_mem_req_s;
endpackage : bfl_pkg

// >>> rtl/bfl_mem.sv
/*
 * Small data memory with registered read data.
 * Assumes one request per cycle; read data valid the cycle after the request.
 */
`timescale 1ns/1ps
module bfl_mem
	import bfl_pkg::*;
(
	// Clock
	input wire logic clk,
	// Request and answer
	input bfl_mem_req_s req,
	input wire logic req_valid,
	output logic [7:0] rdata
);
	logic [7:0] store [MEM_WORDS];

	// Write port
	always_ff @(posedge clk) begin
		if (req_valid && req.we) begin
			store[req.addr] <= req.wdata;
		end
	end

	// Registered read port
	always_ff @(posedge clk) begin
		rdata <= store[req.addr];
	end
endmodule : bfl_mem

// >>> rtl/bfl_exec.sv
/*
 * Execution unit for shifts, flag and bit moves, register moves and data loads and stores.
 * Assumes an APB master that issues an instruction by writing the instruction register.
 */
`timescale 1ns/1ps
module bfl_exec
	import bfl_pkg::*;
(
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Execution status
	output logic BUSY,
	output logic [7:0] FLAGS
);
	typedef enum logic [1:0] {STATE_IDLE, STATE_MEM, STATE_DONE} bfl_state_e;

	bfl_state_e state;
	bfl_instr_s instr;
	bfl_instr_s issue_word;
	logic is_idle;
	logic idle_wr;
	logic exec_done;
	logic load_done;
	logic [7:0] regs [NUM_REGS];
	logic [7:0] flags;
	logic [7:0] operand;
	logic [7:0] mem_rdata;
	logic [15:0] done_count;
	bfl_mem_req_s mem_req;
	logic mem_valid;
	logic apb_acc;
	logic apb_wr;
	logic issue;
	logic [4:0] ptr_lo;
	logic [15:0] ptr_val;
	logic [15:0] ptr_dec;
	logic [15:0] eff_addr;
	logic [7:0] res;
	logic [7:0] src_v;
	logic [7:0] dst_v;
	logic [7:0] next_flags;
	logic next_reg_we;
	logic [7:0] next_reg_val;
	logic next_ptr_we;
	logic [15:0] next_ptr_val;

	// Read a 16-bit pointer pair from the register file
	function automatic logic [15:0] pair_read(input logic [4:0] lo);
		pair_read = {regs[lo + 5'd1], regs[lo]};
	endfunction : pair_read

	// Select pointer pair base index
	function automatic logic [4:0] ptr_base(input logic [1:0] sel);
		case (sel)
			2'd0: ptr_base = PTR_X_LO;
			2'd1: ptr_base = PTR_Y_LO;
			default: ptr_base = PTR_Z_LO;
		endcase
	endfunction : ptr_base

	// Is this a memory access operation
	function automatic logic is_mem(input bfl_op_e op);
		is_mem = (op == OP_POINTER_READ) || (op == OP_OFFSET_POINTER_READ) ||
			(op == OP_ABSOLUTE_READ) || (op == OP_POINTER_WRITE);
	endfunction : is_mem

	// Register window hit: one word per register above the window base
	function automatic logic in_reg_window(input logic [7:0] addr);
		logic [7:0] offset;
		offset = addr - ADDR_REG_BASE;
		in_reg_window = (offset[7] == 1'b0);
	endfunction : in_reg_window

	// Register index inside the window, base taken off first
	function automatic logic [4:0] reg_index(input logic [7:0] addr);
		logic [7:0] offset;
		offset = addr - ADDR_REG_BASE;
		reg_index = offset[6:2];
	endfunction : reg_index

	// APB access decode
	assign apb_acc = PSEL && PENABLE && PREADY;
	assign apb_wr = apb_acc && PWRITE;
	assign is_idle = (state == STATE_IDLE);
	// Writes other than status polls are refused while an instruction runs
	assign idle_wr = apb_wr && is_idle;
	assign issue = idle_wr && (PADDR == ADDR_INSTR);
	assign issue_word = bfl_instr_s'(PWDATA);

	// Completion strobes: register result or loaded byte lands at the next edge
	assign exec_done = (state == STATE_DONE) && !is_mem(instr.op);
	assign load_done = (state == STATE_DONE) && is_mem(instr.op) &&
		(instr.op != OP_POINTER_WRITE);

	// Operand fields for the current instruction
	assign ptr_lo = ptr_base(instr.ptr);
	assign ptr_val = pair_read(ptr_lo);
	assign ptr_dec = ptr_val - 16'h0001;
	assign src_v = regs[instr.src];
	assign dst_v = regs[instr.dst];

	// Effective memory address per addressing form
	always_comb begin
		eff_addr = ptr_val;
		case (instr.op)
			OP_POINTER_READ, OP_POINTER_WRITE: begin
				if (instr.mode == PTR_PRE_DEC) begin
					eff_addr = ptr_dec;
				end
			end
			OP_OFFSET_POINTER_READ: eff_addr = ptr_val + {10'h000, instr.disp};
			OP_ABSOLUTE_READ: eff_addr = {8'h00, operand};
			default: eff_addr = ptr_val;
		endcase
	end

	// Memory request, issued in the first cycle of a two-cycle operation
	assign mem_req.we = (instr.op == OP_POINTER_WRITE);
	assign mem_req.addr = eff_addr[MEM_AW-1:0];
	assign mem_req.wdata = src_v;
	assign mem_valid = (state == STATE_MEM);

	bfl_mem u_mem (
		.clk(CLK),
		.req(mem_req),
		.req_valid(mem_valid),
		.rdata(mem_rdata)
	);

	// Single-cycle results and flag updates
	always_comb begin
		next_flags = flags;
		next_reg_we = 1'b0;
		next_reg_val = dst_v;
		res = dst_v;
		case (instr.op)
			OP_ROTATE_RIGHT_CARRY, OP_ARITH_SHIFT_RIGHT: begin
				if (instr.op == OP_ROTATE_RIGHT_CARRY) begin
					res = {flags[FLAG_C], dst_v[7:1]};
				end else begin
					res = {dst_v[7], dst_v[7:1]};
				end
				next_flags[FLAG_C] = dst_v[0];
				next_flags[FLAG_Z] = (res == 8'h00);
				next_flags[FLAG_N] = res[7];
				next_flags[FLAG_V] = res[7] ^ dst_v[0];
				// Sign flag is not among the shift results, so it is kept
				next_reg_we = 1'b1;
				next_reg_val = res;
			end
			// Nibble exchange, flags untouched
			OP_NIBBLE_SWAP: begin
				next_reg_we = 1'b1;
				next_reg_val = {dst_v[3:0], dst_v[7:4]};
			end
			// Indexed flag ops: bit field names the flag, the rest kept
			OP_FLAG_INDEX_RAISE: next_flags[instr.bit_sel] = 1'b1;
			OP_FLAG_INDEX_DROP: next_flags[instr.bit_sel] = 1'b0;
			OP_BIT_TO_TRANSFER_FLAG: next_flags[FLAG_T] = src_v[instr.bit_sel];
			OP_TRANSFER_FLAG_TO_BIT: begin
				next_reg_we = 1'b1;
				next_reg_val[instr.bit_sel] = flags[FLAG_T];
			end
			OP_REG_COPY: begin
				next_reg_we = 1'b1;
				next_reg_val = src_v;
			end
			OP_IMMEDIATE_LOAD: begin
				next_reg_we = 1'b1;
				next_reg_val = operand;
			end
			default: begin
				next_reg_we = 1'b0;
			end
		endcase
	end

	// Pointer update for post-increment and pre-decrement forms
	always_comb begin
		next_ptr_we = 1'b0;
		next_ptr_val = ptr_val;
		if (instr.op == OP_POINTER_READ || instr.op == OP_POINTER_WRITE) begin
			if (instr.mode == PTR_POST_INC) begin
				next_ptr_we = 1'b1;
				next_ptr_val = ptr_val + 16'h0001;
			end else if (instr.mode == PTR_PRE_DEC) begin
				next_ptr_we = 1'b1;
				next_ptr_val = ptr_dec;
			end
		end
	end

	// Sequencer: one cycle for register ops, two for memory ops
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			state <= STATE_IDLE;
		end else begin
			case (state)
				STATE_IDLE: begin
					// Op field sits in the top bits of the written word
					if (issue) begin
						state <= is_mem(issue_word.op) ? STATE_MEM : STATE_DONE;
					end
				end
				// Memory request goes out during this state
				STATE_MEM: state <= STATE_DONE;
				STATE_DONE: state <= STATE_IDLE;
				default: state <= STATE_IDLE;
			endcase
		end
	end

	// Instruction and operand latch
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			instr <= '0;
			operand <= 8'h00;
		end else begin
			if (issue) begin
				instr <= issue_word;
			end
			// Operand holds the immediate value or the absolute address
			if (idle_wr && PADDR == ADDR_OPERAND) begin
				operand <= PWDATA[7:0];
			end
		end
	end

	// Status flags: memory and move ops leave them alone
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			flags <= FLAGS_RESET;
		end else if (exec_done) begin
			flags <= next_flags;
		end else if (idle_wr && PADDR == ADDR_FLAGS) begin
			// Software load of the whole flag register
			flags <= PWDATA[7:0];
		end
	end

	// Register file writes: execution, pointer updates, load data, software access
	always_ff @(posedge CLK) begin
		if (exec_done) begin
			// Single-cycle result into the destination
			if (next_reg_we) begin
				regs[instr.dst] <= next_reg_val;
			end
			// Word copy moves an even-aligned pair
			if (instr.op == OP_REG_PAIR_COPY) begin
				regs[{instr.dst[4:1], 1'b0}] <= regs[{instr.src[4:1], 1'b0}];
				regs[{instr.dst[4:1], 1'b1}] <= regs[{instr.src[4:1], 1'b1}];
			end
		end else if (state == STATE_MEM) begin
			// Pointer written back in the access cycle
			if (next_ptr_we) begin
				regs[ptr_lo] <= next_ptr_val[7:0];
				regs[ptr_lo + 5'd1] <= next_ptr_val[15:8];
			end
		end else if (load_done) begin
			// Loaded byte comes from the registered read port
			regs[instr.dst] <= mem_rdata;
		end else if (idle_wr && in_reg_window(PADDR)) begin
			// Software write into the register window
			regs[reg_index(PADDR)] <= PWDATA[7:0];
		end
	end

	// Completed instruction counter
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			done_count <= 16'h0000;
		end else if (state == STATE_DONE) begin
			done_count <= done_count + 16'h0001;
		end
	end

	// APB answer: zero wait states, unmapped reads return zero with error
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			PRDATA <= 32'h0000_0000;
			PSLVERR <= 1'b0;
		end else if (PSEL && !PENABLE) begin
			PSLVERR <= 1'b0;
			PRDATA <= 32'h0000_0000;
			if (PADDR == ADDR_INSTR) begin
				PRDATA <= 32'(instr);
			end else if (PADDR == ADDR_OPERAND) begin
				PRDATA <= {24'h000000, operand};
			end else if (PADDR == ADDR_FLAGS) begin
				PRDATA <= {24'h000000, flags};
			end else if (PADDR == ADDR_STATUS) begin
				// Busy in bit 16 above the completion count
				PRDATA <= {15'h0000, !is_idle, done_count};
			end else if (in_reg_window(PADDR)) begin
				// Register byte, zero-extended
				PRDATA <= {24'h000000, regs[reg_index(PADDR)]};
			end else begin
				PSLVERR <= 1'b1;
			end
		end
	end

	// Ready always high once out of reset
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			PREADY <= 1'b0;
		end else begin
			PREADY <= 1'b1;
		end
	end

	// Status outputs
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			BUSY <= 1'b0;
			FLAGS <= FLAGS_RESET;
		end else begin
			BUSY <= !is_idle || issue;
			FLAGS <= flags;
		end
	end
endmodule : bfl_exec

// >>> verification/bfl_exec_chk.sv
/* Port checker for the execution unit.
 * Assumes it is bound into bfl_exec below. */
`timescale 1ns/1ps
module bfl_exec_chk
	import bfl_pkg::*;
(
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// Bus
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	// Status
	input wire logic BUSY,
	input wire logic [7:0] FLAGS
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RST_N);
	logic acc;
	logic fwr;
	logic [4:0] opf;
	logic [2:0] act_q;
	logic [7:0] fw_q;
	// Completed bus access and flag write
	assign acc = PSEL && PENABLE && PREADY;
	assign fwr = acc && PWRITE && PADDR == ADDR_FLAGS && !BUSY;
	assign opf = PWDATA[31:27];
	// Recent activity and last flag write value
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			act_q <= 3'h0;
			fw_q <= 8'h00;
		end else begin
			act_q <= {act_q[1:0], BUSY | fwr};
			if (fwr) begin
				fw_q <= PWDATA[7:0];
			end
		end
	end
	sequence issue_s;
		acc && PWRITE && PADDR == ADDR_INSTR && !BUSY && opf != 5'h00;
	endsequence
	AST_BUSY_RISE: assert property (issue_s |-> ##[1:2] BUSY)
		else $error("busy missing after issue");
	AST_BUSY_BOUND: assert property ($rose(BUSY) |-> ##[1:3] !BUSY)
		else $error("instruction too long");
	AST_FLAGS_CAUSE: assert property ($changed(FLAGS) |-> act_q != 3'h0)
		else $error("flags changed without cause");
	AST_FLAG_WRITE: assert property (fwr |-> ##[1:2] FLAGS == fw_q)
		else $error("flag write lost");
	AST_FLAGS_KEEP: assert property (issue_s ##0 opf >= 5'h08 |=> $stable(FLAGS)[*4])
		else $error("move changed flags");
	AST_ONE_FLAG: assert property (issue_s ##0 (opf inside {[5'h04:5'h07]})
		|=> ($countones(FLAGS ^ $past(FLAGS)) < 2)[*4]) else $error("several flags changed");
	AST_RAISE_UP: assert property (issue_s ##0 opf == OP_FLAG_INDEX_RAISE
		|=> ((~FLAGS & $past(FLAGS)) == 8'h00)[*4]) else $error("raise cleared a flag");
	AST_DROP_DOWN: assert property (issue_s ##0 opf == OP_FLAG_INDEX_DROP
		|=> ((FLAGS & ~$past(FLAGS)) == 8'h00)[*4]) else $error("drop set a flag");
endmodule : bfl_exec_chk
bind bfl_exec bfl_exec_chk u_chk (.CLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
	.PRDATA, .PREADY, .PSLVERR, .BUSY, .FLAGS);

// >>> verification/bfl_host.sv
/* Bus master standing in for the instruction stream.
 * Assumes one clock; counts a transfer that never completes. */
`timescale 1ns/1ps
module bfl_host
	import bfl_pkg::*;
(
	// Clock
	input wire logic clk,
	// Bus
	output logic psel = 1'h0,
	output logic penable = 1'h0,
	output logic pwrite = 1'h0,
	output logic [7:0] paddr = 8'h00,
	output logic [31:0] pwdata = 32'h0,
	input wire logic [31:0] prdata,
	input wire logic pready
);
	int tmo = 0;
	// One transfer, request held until ready is seen
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		logic rdy;
		n = 0;
		rdy = 1'h0;
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		// Ready and read data taken at the same rising edge
		do begin
			@(posedge clk);
			rdy = pready;
			q = prdata;
			n++;
		end while (rdy !== 1'h1 && n < 50);
		if (rdy !== 1'h1) tmo++;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : xfer
endmodule : bfl_host

// >>> verification/testbench.sv
/* Self-checking bench for the execution unit.
 * Assumes the bus master model and the checker compile first. */
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
	$display("Error %s exp %h got %h", n, e, g); end end
module testbench
	import bfl_pkg::*;
;
	logic CLK = 1'h0;
	logic RST_N = 1'h0;
	logic psel, penable, pwrite, pready, pslverr, busy;
	logic [7:0] paddr, flags;
	logic [31:0] pwdata, prdata, v;
	int err_total = 0;
	int samples_checked = 0;
	// Clock
	initial begin
		forever #5 CLK = ~CLK;
	end
	// Unit and bus master
	bfl_exec u_dut (.CLK, .RST_N, .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .BUSY(busy), .FLAGS(flags));
	bfl_host u_host (.clk(CLK), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready);
	task results;
		if (err_total == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : results
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		u_host.xfer(w, a, d, v);
		if (u_host.tmo != 0) begin
			err_total++;
			results();
		end
	endtask : bus
	// Issue one instruction and poll until idle
	task ex(input bfl_op_e op, input logic [4:0] d, input logic [4:0] s = 5'h00,
		input logic [2:0] b = 3'h0, input bfl_ptr_mode_e m = PTR_PLAIN,
		input logic [1:0] p = 2'h0, input logic [5:0] q = 6'h00);
		int n;
		bfl_instr_s w;
		w = '{op, m, p, d, s, b, q, 4'h0};
		bus(1'h1, ADDR_INSTR, w);
		n = 0;
		do begin
			bus(1'h0, ADDR_STATUS, 32'h0);
			n++;
		end while (v[16] !== 1'h0 && n < 20);
		if (v[16] !== 1'h0) begin
			err_total++;
			results();
		end
	endtask : ex
	task li(input logic [4:0] n, input logic [7:0] k);
		bus(1'h1, ADDR_OPERAND, {24'h0, k});
		ex(OP_IMMEDIATE_LOAD, n);
	endtask : li
	task rr(input logic [4:0] n, input logic [7:0] e);
		bus(1'h0, ADDR_REG_BASE + {1'h0, n, 2'h0}, 32'h0);
		`CHK("register", e, v[7:0])
		`CHK("slave error", 1'h0, pslverr)
	endtask : rr
	task fl(input logic [7:0] f);
		bus(1'h1, ADDR_FLAGS, {24'h0, f});
	endtask : fl
	// Main sequence
	initial begin
		repeat (4) @(posedge CLK);
		RST_N <= 1'h1;
		repeat (2) @(posedge CLK);
		fl(8'h5a);
		li(5'h10, 8'ha5);
		rr(5'h10, 8'ha5);
		li(5'h1a, 8'h05);
		li(5'h1b, 8'h00);
		ex(OP_POINTER_WRITE, 5'h00, 5'h10, 3'h0, PTR_POST_INC);
		rr(5'h1a, 8'h06);
		ex(OP_POINTER_READ, 5'h11, 5'h00, 3'h0, PTR_PRE_DEC);
		rr(5'h11, 8'ha5);
		rr(5'h1a, 8'h05);
		li(5'h1e, 8'h08);
		li(5'h1f, 8'h00);
		ex(OP_POINTER_WRITE, 5'h00, 5'h10, 3'h0, PTR_PRE_DEC, 2'h2);
		ex(OP_POINTER_READ, 5'h12, 5'h00, 3'h0, PTR_POST_INC, 2'h2);
		rr(5'h12, 8'ha5);
		rr(5'h1e, 8'h08);
		bus(1'h1, ADDR_OPERAND, 32'h7);
		ex(OP_ABSOLUTE_READ, 5'h13);
		rr(5'h13, 8'ha5);
		li(5'h1c, 8'h03);
		li(5'h1d, 8'h00);
		ex(OP_OFFSET_POINTER_READ, 5'h14, 5'h00, 3'h0, PTR_PLAIN, 2'h1, 6'h02);
		rr(5'h14, 8'ha5);
		rr(5'h1c, 8'h03);
		ex(OP_REG_PAIR_COPY, 5'h16, 5'h10);
		rr(5'h17, 8'ha5);
		ex(OP_REG_COPY, 5'h15, 5'h11);
		rr(5'h15, 8'ha5);
		ex(OP_POINTER_READ, 5'h0f, 5'h00, 3'h0, PTR_PLAIN, 2'h0);
		rr(5'h0f, 8'ha5);
		rr(5'h1a, 8'h05);
		`CHK("flags", 8'h5a, flags)
		// Every flag raised alone, then dropped alone
		for (int i = 0; i < 8; i++) begin
			fl(8'h00);
			ex(OP_FLAG_INDEX_RAISE, 5'h00, 5'h00, i[2:0]);
			`CHK("raise", 8'h01 << i, flags)
			fl(8'hff);
			ex(OP_FLAG_INDEX_DROP, 5'h00, 5'h00, i[2:0]);
			`CHK("drop", ~(8'h01 << i), flags)
		end
		fl(8'h00);
		ex(OP_BIT_TO_TRANSFER_FLAG, 5'h00, 5'h10, 3'h5);
		`CHK("to transfer", 8'h40, flags)
		li(5'h18, 8'h00);
		ex(OP_TRANSFER_FLAG_TO_BIT, 5'h18, 5'h00, 3'h3);
		rr(5'h18, 8'h08);
		`CHK("from transfer", 8'h40, flags)
		fl(8'h01);
		ex(OP_ROTATE_RIGHT_CARRY, 5'h10);
		rr(5'h10, 8'hd2);
		`CHK("rotate", 8'h05, flags)
		fl(8'h00);
		li(5'h19, 8'h81);
		ex(OP_ARITH_SHIFT_RIGHT, 5'h19);
		rr(5'h19, 8'hc0);
		`CHK("shift", 8'h05, flags)
		ex(OP_NIBBLE_SWAP, 5'h19);
		rr(5'h19, 8'h0c);
		`CHK("swap", 8'h05, flags)
		results();
	end
endmodule : testbench
